//--- common/mats_consts.svh
// offsets, field positions, codes, characters and times of the modem sequencer
// assumes inclusion by the sequencer and the bench; byte addresses on a 10-bit port
`ifndef MATS_CONSTS_SVH
`define MATS_CONSTS_SVH
`define MATS_A_CTRL     10'h000
`define MATS_A_STAT     10'h004
`define MATS_A_FLAG     10'h008
`define MATS_A_RTRY     10'h00c
`define MATS_A_PROT     10'h010
`define MATS_A_MEM      10'h100
`define MATS_A_MEM_END  10'h218
`define MATS_MEM_WORDS  70
`define MATS_GEN_BASE   7'h00
`define MATS_INIT_BASE  7'h0f
`define MATS_DIAL_BASE  7'h28
`define MATS_GEN_LEN    7'h1e
`define MATS_INIT_LEN   7'h32
`define MATS_DIAL_LEN   7'h3c
`define MATS_B_EN       0
`define MATS_B_GEN      1
`define MATS_B_DISC     5
`define MATS_S_ANSF     1
`define MATS_S_ANSR     2
`define MATS_S_ORIG     3
`define MATS_S_DISC     4
`define MATS_RTRY_RST   16'h0003
`define MATS_C_OFF      16'h0000
`define MATS_C_READY    16'h000a
`define MATS_C_RUN      16'h0014
`define MATS_C_WAIT     16'h001e
`define MATS_C_LINE     16'h0028
`define MATS_C_OK       16'h0032
`define MATS_C_PROG     16'h003c
`define MATS_C_SIMUL    16'h003d
`define MATS_C_ONLINE   16'h003e
`define MATS_C_EXEC     16'h003f
`define MATS_CH_CR      8'h0d
`define MATS_CH_LF      8'h0a
`define MATS_CH_A       8'h41
`define MATS_CH_T       8'h54
`define MATS_CH_D       8'h44
`define MATS_CH_Z       8'h5a
`define MATS_CH_O       8'h4f
`define MATS_CH_K       8'h4b
`define MATS_CH_SP      8'h20
`define MATS_CH_DEL     8'h7f
`define MATS_DEF_WORDS  17
`define MATS_DEF_INIT   {"E0Q0V1&D2&C1\\V0X4&K3\\A0\\N5S0=2&W", 8'h0d, 8'h00}
`define MATS_CLK_HZ     64'd50000000
`define MATS_RSP_TO_MS  64'd2000
`define MATS_CONN_TO_S  64'd60
`define MATS_RETRY_S    64'd90
`endif

//--- common/mats_pkg.sv
// types shared by the modem sequencer
// assumes nothing of its surroundings
`default_nettype none
package mats_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_TX   = 3'b001,
        ST_RSP  = 3'b010,
        ST_DCD  = 3'b011,
        ST_GAP  = 3'b100
    } mats_state_e;
    // order gives the low digit of the run and wait status codes
    typedef enum logic [2:0] {
        SP_OINIT = 3'b000,
        SP_OATZ  = 3'b001,
        SP_DIAL  = 3'b010,
        SP_DISC  = 3'b011,
        SP_GEN   = 3'b100,
        SP_AINIT = 3'b101,
        SP_ARST  = 3'b110
    } mats_step_e;
endpackage
`default_nettype wire

//--- rtl/mats_sequencer.sv
// modem command sequencer: string store, command transmit, result parsing
// assumes a byte UART on the same clock and an asynchronous carrier-detect pin
//
// Chosen here: the placing of the registers and the plain strobed port.
`default_nettype none
`include "mats_consts.svh"
module mats_sequencer
    import mats_pkg::*;
#(
    parameter logic [32:0] RSP_CYC   = 33'(`MATS_RSP_TO_MS * (`MATS_CLK_HZ / 64'd1000)),
    parameter logic [32:0] CONN_CYC  = 33'(`MATS_CONN_TO_S * `MATS_CLK_HZ),
    parameter logic [32:0] RETRY_CYC = 33'(`MATS_RETRY_S * `MATS_CLK_HZ)
)
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic  [9:0] regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output var  logic [15:0] regRdData,
    output var  logic  [7:0] txData,
    output var  logic        txValid,
    input  wire logic        txReady,
    input  wire logic  [7:0] rxData,
    input  wire logic        rxValid,
    input  wire logic        dcdPin,
    output logic             dtr,
    output var  logic        lineConnected,
    output logic             userProtocol,
    output logic             busy
);
    localparam logic [16*`MATS_DEF_WORDS-1:0] DEF_INIT = `MATS_DEF_INIT;

    logic               enable;
    logic               enPrev;
    logic        [15:0] commandRetryCount;
    logic        [15:0] onlineProtocolSelect;
    logic        [15:0] modemStatusCode;
    logic        [15:0] strMem [`MATS_MEM_WORDS];
    logic         [6:0] doneFlag;
    logic         [6:0] failFlag;
    mats_state_e        state;
    mats_step_e         step;
    logic         [6:0] pos;
    logic               sentCr;
    logic        [32:0] timer;
    logic        [15:0] retryLeft;
    logic         [2:0] matchIdx;
    logic               dcdMeta;
    logic               dcdSync;

    // register decode
    wire        wrCtrl  = regWrite && regAddr == `MATS_A_CTRL;
    wire        wrRtry  = regWrite && regAddr == `MATS_A_RTRY;
    wire        wrProt  = regWrite && regAddr == `MATS_A_PROT;
    wire        inMem   = regAddr >= `MATS_A_MEM && regAddr < `MATS_A_MEM_END;
    wire        wrMem   = regWrite && inMem;
    wire  [9:0] memOff  = regAddr - `MATS_A_MEM;
    wire  [6:0] memIdx  = memOff[8:2];
    wire        enRise  = enable && !enPrev;
    wire [15:0] ctrlRd  = {15'h0000, enable};
    wire [15:0] flagRd  = {lineConnected, failFlag, 1'b0, doneFlag};
    wire [15:0] rdMux   = regAddr == `MATS_A_CTRL ? ctrlRd :
                          regAddr == `MATS_A_STAT ? modemStatusCode :
                          regAddr == `MATS_A_FLAG ? flagRd :
                          regAddr == `MATS_A_RTRY ? commandRetryCount :
                          regAddr == `MATS_A_PROT ? onlineProtocolSelect :
                          inMem ? strMem[memIdx] : 16'h0000;

    // start decode; start bits are write pulses, so each fires once
    wire  [4:0] startReq  = wrCtrl ? regWrData[`MATS_B_DISC:`MATS_B_GEN] : 5'h00;
    wire        anyStart  = |startReq;
    wire        multi     = |(startReq & (startReq - 5'h01));
    wire        idleEn    = enable && state == ST_IDLE;
    wire        discReq   = startReq[`MATS_S_DISC];
    wire        startOk   = idleEn && anyStart && !multi && (lineConnected == discReq);
    wire        onlineErr = idleEn && anyStart && !multi && lineConnected && !discReq;
    wire mats_step_e startStep = startReq[`MATS_S_ANSF] ? SP_AINIT :
                                 startReq[`MATS_S_ANSR] ? SP_ARST :
                                 startReq[`MATS_S_ORIG] ? SP_OINIT :
                                 discReq ? SP_DISC : SP_GEN;
    wire  [6:0] clrMask   = startReq[`MATS_S_ANSF] ? 7'h60 :
                            startReq[`MATS_S_ORIG] ? 7'h07 : 7'h01 << startStep;

    // outgoing character: prefix, stored or fixed body, then LF after CR
    wire        fixedZ   = step == SP_OATZ || step == SP_ARST;
    wire  [6:0] preLen   = step == SP_DIAL ? 7'h03 : 7'h02;
    wire  [6:0] bodyIdx  = pos - preLen;
    wire  [6:0] base     = step == SP_GEN ? `MATS_GEN_BASE :
                           step == SP_DIAL ? `MATS_DIAL_BASE : `MATS_INIT_BASE;
    wire  [6:0] lim      = step == SP_GEN ? `MATS_GEN_LEN :
                           step == SP_DIAL ? `MATS_DIAL_LEN : `MATS_INIT_LEN;
    wire        overRun  = bodyIdx >= lim;
    wire  [6:0] wordIdx  = overRun ? base : base + {1'b0, bodyIdx[6:1]};
    wire [15:0] memWord  = strMem[wordIdx];
    wire  [7:0] memChar  = bodyIdx[0] ? memWord[7:0] : memWord[15:8];
    wire  [7:0] preChar  = pos == 7'h00 ? `MATS_CH_A :
                           pos == 7'h01 ? `MATS_CH_T : `MATS_CH_D;
    wire  [7:0] zChar    = bodyIdx == 7'h00 ? `MATS_CH_Z : `MATS_CH_CR;
    wire  [7:0] bodyChar = fixedZ ? zChar : memChar;
    wire  [7:0] nextChar = sentCr ? `MATS_CH_LF : pos < preLen ? preChar : bodyChar;
    wire        printable = memChar >= `MATS_CH_SP && memChar < `MATS_CH_DEL;
    wire        badChar  = !sentCr && pos >= preLen && !fixedZ &&
                           (overRun || (memChar != `MATS_CH_CR && !printable));
    wire        txFire   = txValid && txReady;
    wire        txDone   = txFire && sentCr;
    wire        progErr  = state == ST_TX && !txValid && badChar;

    // result parsing: expects CR LF O K CR LF
    wire  [7:0] expChar  = matchIdx == 3'h2 ? `MATS_CH_O :
                           matchIdx == 3'h3 ? `MATS_CH_K :
                           matchIdx[0] ? `MATS_CH_LF : `MATS_CH_CR;
    wire        rspOk    = rxValid && matchIdx == 3'h5 && rxData == `MATS_CH_LF;
    wire        rspBad   = rxValid && matchIdx == 3'h2 && rxData != `MATS_CH_O &&
                           rxData != `MATS_CH_CR && rxData != `MATS_CH_LF;
    wire        carrierOk = step == SP_DISC ? !dcdSync : dcdSync;
    wire        succ     = state == ST_RSP ? rspOk : state == ST_DCD && carrierOk;
    wire        waiting  = state == ST_RSP || state == ST_DCD;
    wire        failNow  = waiting && !succ &&
                           (timer == 33'h0 || (state == ST_RSP && rspBad));
    wire        isLast   = step == SP_DIAL || step == SP_DISC ||
                           step == SP_GEN || step == SP_ARST;
    wire        chainNext = succ && !isLast;
    wire        retryGo  = state == ST_GAP && timer == 33'h0;
    wire        launch   = startOk || chainNext || retryGo;
    wire mats_step_e chainStep = step == SP_OINIT ? SP_OATZ :
                                 step == SP_OATZ ? SP_DIAL : SP_ARST;
    wire mats_step_e launchStep = startOk ? startStep : chainNext ? chainStep : step;

    // dtr drop is the hang-up, so the modem must hang up on it
    assign dtr          = enable && !(state != ST_IDLE && step == SP_DISC);
    assign userProtocol = lineConnected && onlineProtocolSelect[0];
    assign busy         = state != ST_IDLE;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable <= 1'b0;
            enPrev <= 1'b0;
            commandRetryCount <= `MATS_RTRY_RST;
            onlineProtocolSelect <= 16'h0000;
            regRdData <= 16'h0000;
        end
        else
        begin
            enPrev <= enable;
            if (wrCtrl)
                enable <= regWrData[`MATS_B_EN];
            if (wrRtry)
                commandRetryCount <= regWrData;
            if (wrProt)
                onlineProtocolSelect <= regWrData;
            regRdData <= regRead ? rdMux : 16'h0000;
        end
    end

    // string store has no reset; the default init string lands on enable
    always_ff @(posedge clock)
    begin
        if (enRise)
            for (int i = 0; i < `MATS_DEF_WORDS; i++)
                strMem[`MATS_INIT_BASE + i] <=
                    DEF_INIT[16*`MATS_DEF_WORDS-1-16*i -: 16];
        if (wrMem)
            strMem[memIdx] <= regWrData;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dcdMeta <= 1'b0;
            dcdSync <= 1'b0;
        end
        else
        begin
            dcdMeta <= dcdPin;
            dcdSync <= dcdMeta;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pos <= 7'h00;
            sentCr <= 1'b0;
            txValid <= 1'b0;
            txData <= 8'h00;
        end
        else if (launch || !enable)
        begin
            pos <= 7'h00;
            sentCr <= 1'b0;
            txValid <= 1'b0;
        end
        else if (state == ST_TX && !txValid && !badChar)
        begin
            txValid <= 1'b1;
            txData <= nextChar;
        end
        else if (txFire)
        begin
            txValid <= 1'b0;
            pos <= pos + 7'h01;
            if (txData == `MATS_CH_CR)
                sentCr <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            matchIdx <= 3'h0;
        else if (state != ST_RSP)
            matchIdx <= 3'h0;
        else if (rxValid)
            matchIdx <= rxData == expChar ? matchIdx + 3'h1 :
                        rxData == `MATS_CH_CR ? 3'h1 : 3'h0;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            timer <= 33'h0;
        else if (launch && launchStep == SP_DISC)
            timer <= CONN_CYC;
        else if (txDone)
            timer <= step == SP_DIAL ? CONN_CYC : RSP_CYC;
        else if (failNow && retryLeft != 16'h0000)
            timer <= RETRY_CYC;
        else if (timer != 33'h0)
            timer <= timer - 33'h1;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            retryLeft <= 16'h0000;
        else if (launch && !retryGo)
            retryLeft <= commandRetryCount;
        else if (failNow && retryLeft != 16'h0000)
            retryLeft <= retryLeft - 16'h0001;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            step <= SP_GEN;
        end
        else if (!enable)
            state <= ST_IDLE;
        else if (launch)
        begin
            state <= launchStep == SP_DISC ? ST_DCD : ST_TX;
            step <= launchStep;
        end
        else
            unique case (state)
                ST_IDLE: state <= ST_IDLE;
                ST_TX:
                    if (progErr)
                        state <= ST_IDLE;
                    else if (txDone)
                        state <= step == SP_DIAL ? ST_DCD : ST_RSP;
                ST_RSP, ST_DCD:
                    if (failNow)
                        state <= retryLeft != 16'h0000 ? ST_GAP : ST_IDLE;
                    else if (succ)
                        state <= ST_IDLE;
                ST_GAP: state <= ST_GAP;
                default: state <= ST_IDLE;
            endcase
    end

    // a start only happens while idle, so it never meets a set in the same cycle
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            doneFlag <= 7'h00;
            failFlag <= 7'h00;
            lineConnected <= 1'b0;
        end
        else if (!enable)
            lineConnected <= 1'b0;
        else
        begin
            if (startOk)
            begin
                doneFlag <= doneFlag & ~clrMask;
                failFlag <= failFlag & ~clrMask;
            end
            if (succ)
                doneFlag[step] <= 1'b1;
            if ((failNow && retryLeft == 16'h0000) || progErr)
                failFlag[step] <= 1'b1;
            if (succ && step == SP_DIAL)
                lineConnected <= 1'b1;
            if (succ && step == SP_DISC)
                lineConnected <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            modemStatusCode <= `MATS_C_OFF;
        else if (!enable)
            modemStatusCode <= `MATS_C_OFF;
        else if (enRise)
            modemStatusCode <= `MATS_C_READY;
        else if (multi && idleEn)
            modemStatusCode <= `MATS_C_SIMUL;
        else if (onlineErr)
            modemStatusCode <= `MATS_C_ONLINE;
        else if (launch)
            modemStatusCode <= `MATS_C_RUN + {13'h0000, launchStep};
        else if (progErr)
            modemStatusCode <= `MATS_C_PROG;
        else if (failNow)
            modemStatusCode <= retryLeft != 16'h0000 ?
                `MATS_C_WAIT + {13'h0000, step} : `MATS_C_EXEC;
        else if (succ)
            modemStatusCode <= step == SP_DIAL ? `MATS_C_LINE :
                step == SP_DISC ? `MATS_C_READY : `MATS_C_OK;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_simul;
        idleEn && multi |=> modemStatusCode == `MATS_C_SIMUL && state == ST_IDLE;
    endproperty
    a_simul: assert property (p_simul) else $error("simultaneous starts not refused");

    property p_online;
        onlineErr |=> modemStatusCode == `MATS_C_ONLINE && state == ST_IDLE;
    endproperty
    a_online: assert property (p_online) else $error("online start not refused");

    property p_busy;
        state == ST_TX && !progErr && anyStart |=> step == $past(step);
    endproperty
    a_busy: assert property (p_busy) else $error("start taken while busy");

    property p_gen;
        state == ST_RSP && step == SP_GEN && rspOk
            |=> doneFlag[SP_GEN] && modemStatusCode == `MATS_C_OK;
    endproperty
    a_gen: assert property (p_gen) else $error("general done not reported");

    property p_prefix;
        state == ST_TX && pos == 7'h00 && txValid |-> txData == `MATS_CH_A;
    endproperty
    a_prefix: assert property (p_prefix) else $error("prefix not first");

    property p_lf;
        state == ST_TX && txFire && txData == `MATS_CH_CR
            |=> !txValid ##1 (txValid && txData == `MATS_CH_LF);
    endproperty
    a_lf: assert property (p_lf) else $error("LF does not follow CR");

    property p_wait;
        failNow && retryLeft != 16'h0000
            |=> state == ST_GAP && modemStatusCode == `MATS_C_WAIT + {13'h0000, $past(step)};
    endproperty
    a_wait: assert property (p_wait) else $error("retry wait code wrong");

    property p_exec;
        failNow && retryLeft == 16'h0000 |=> modemStatusCode == `MATS_C_EXEC && !busy;
    endproperty
    a_exec: assert property (p_exec) else $error("final failure not reported");

    property p_off;
        !enable |=> modemStatusCode == `MATS_C_OFF && !busy;
    endproperty
    a_off: assert property (p_off) else $error("disabled status not zero");

    property p_chain;
        state == ST_RSP && step == SP_AINIT && rspOk
            |=> step == SP_ARST && state == ST_TX && doneFlag[SP_AINIT];
    endproperty
    a_chain: assert property (p_chain) else $error("answer reset not chained");

    property p_dial;
        state == ST_DCD && step == SP_DIAL && dcdSync
            |=> lineConnected && modemStatusCode == `MATS_C_LINE;
    endproperty
    a_dial: assert property (p_dial) else $error("carrier not taken as connect");

    c_gen: cover property (state == ST_RSP && step == SP_GEN && rspOk);
    c_ans: cover property (state == ST_RSP && step == SP_ARST && rspOk);
    c_retry: cover property (retryGo);
    c_simul: cover property (idleEn && multi);
endmodule
`default_nettype wire

//--- bench/mats_modem_model.sv
// behavioural dial-up modem facing the sequencer's byte ports
// assumes one clock shared with the sequencer; answers each command after its LF
`default_nettype none
module mats_modem_model
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [7:0] txData,
    input  wire logic       txValid,
    input  wire logic       dtr,
    input  wire logic       replyOk,
    input  wire logic       slow,
    input  wire logic       carrier,
    output logic            txReady,
    output var  logic [7:0] rxData,
    output var  logic       rxValid,
    output logic            dcdPin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0]  cnt;
    logic [2:0]  left;
    logic [47:0] msg;
    // slow mode stalls every other cycle, as hardware flow control would
    assign txReady = !slow || cnt[0];
    // carrier is set by the bench; a low dtr hangs up and drops it at once
    assign dcdPin = dtr & carrier;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= 6'h00;
            left <= 3'h0;
            msg <= 48'h0;
            rxValid <= 1'b0;
            rxData <= 8'h00;
        end
        else
        begin
            cnt <= cnt + 6'h01;
            rxValid <= 1'b0;
            // no echo; word result, "NO" makes the third char a failure
            if (txValid && txReady && txData == 8'h0a)
            begin
                left <= 3'h6;
                msg <= {8'h0d, 8'h0a, replyOk ? "OK" : "NO", 8'h0d, 8'h0a};
            end
            else if (left != 3'h0 && cnt[1:0] == 2'h0)
            begin
                rxValid <= 1'b1;
                rxData <= msg[47:40];
                msg <= msg << 8;
                left <= left - 3'h1;
            end
            else
                rxData <= ~rxData;
        end
    end
endmodule
`default_nettype wire

//--- bench/tb.sv
// self-checking bench for the modem sequencer
// assumes the modem model takes bytes promptly or slowly as the bench commands
`default_nettype none
`include "mats_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, rst_n, regWrite, regRead, txValid, txReady, rxValid, dcdPin, dtr;
    logic        lineConnected, userProtocol, busy, replyOk, slow, carrier;
    logic [9:0]  regAddr;
    logic [15:0] regWrData, regRdData, rdv;
    logic [7:0]  txData, rxData;
    logic [7:0]  sent[$];
    int          mismatches, totalChecks;
    mats_sequencer #(.RSP_CYC(33'd200), .CONN_CYC(33'd300), .RETRY_CYC(33'd50)) dut (
        .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .txData(txData),
        .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
        .dcdPin(dcdPin), .dtr(dtr), .lineConnected(lineConnected),
        .userProtocol(userProtocol), .busy(busy));
    mats_modem_model modem (.clock(clock), .rst_n(rst_n), .txData(txData),
        .txValid(txValid), .dtr(dtr), .replyOk(replyOk), .slow(slow), .txReady(txReady),
        .rxData(rxData), .rxValid(rxValid), .dcdPin(dcdPin), .carrier(carrier));
    always @(posedge clock)
        if (txValid === 1'b1 && txReady === 1'b1)
            sent.push_back(txData);
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic give_verdict;
        $display("mismatches=%0d checks=%0d", mismatches, totalChecks);
        if (mismatches == 0 && totalChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 rdv = regRdData;
    endtask
    task automatic chk_rd(input logic [9:0] a, input logic [15:0] exp);
        rd(a);
        chk(rdv, exp);
    endtask
    task automatic wait_idle;
        int n;
        repeat (2) @(posedge clock);
        #1;
        for (n = 0; n < 4000 && busy !== 1'b0; n++)
            @(posedge clock) #1;
        if (n == 4000)
        begin
            mismatches++;
            give_verdict();
        end
    endtask
    task automatic wait_status(input logic [15:0] code);
        int n;
        for (n = 0; n < 300 && rdv !== code; n++)
            rd(`MATS_A_STAT);
        chk(rdv, code);
        if (n == 300)
            give_verdict();
    endtask
    // byte count and every byte on the wire, then the log restarts
    task automatic chk_tx(input string s);
        chk(16'(sent.size()), 16'(s.len()));
        for (int i = 0; i < s.len() && i < sent.size(); i++)
            chk({8'h00, sent[i]}, {8'h00, s[i]});
        sent.delete();
    endtask
    task automatic t_reset;
        chk_rd(`MATS_A_STAT, 16'h0000);
        chk_rd(`MATS_A_RTRY, 16'h0003);
        chk_rd(10'h3fc, 16'h0000);
    endtask
    task automatic t_enable;
        wr(`MATS_A_CTRL, 16'h0001);
        chk_rd(`MATS_A_STAT, 16'h000a);
        chk_rd(`MATS_A_MEM + 10'd60, 16'h4530);
        chk_rd(`MATS_A_MEM + 10'd124, 16'h0d00);
    endtask
    task automatic t_gen_fail;
        replyOk <= 1'b0;
        wr(`MATS_A_RTRY, 16'h0001);
        chk_rd(`MATS_A_RTRY, 16'h0001);
        wr(`MATS_A_MEM, 16'h4530);
        wr(`MATS_A_MEM + 10'd4, 16'h0d41);
        wr(`MATS_A_CTRL, 16'h0003);
        chk_rd(`MATS_A_STAT, 16'h0018);
        wait_status(16'h0022);
        wait_idle();
        chk_rd(`MATS_A_STAT, 16'h003f);
        rd(`MATS_A_FLAG);
        chk(rdv & 16'h1010, 16'h1000);
        sent.delete();
    endtask
    task automatic t_gen_ok;
        replyOk <= 1'b1;
        wr(`MATS_A_CTRL, 16'h0003);
        wait_idle();
        chk_tx("ATE0\x0d\x0a");
        chk_rd(`MATS_A_STAT, 16'h0032);
        rd(`MATS_A_FLAG);
        chk(rdv & 16'h1010, 16'h0010);
    endtask
    task automatic t_multi;
        wr(`MATS_A_CTRL, 16'h0007);
        chk_rd(`MATS_A_STAT, 16'h003d);
        chk({15'h0000, busy}, 16'h0000);
        chk(16'(sent.size()), 16'h0000);
    endtask
    // a control byte in the stored body stops the command at that byte, after ATE
    task automatic t_prog;
        wr(`MATS_A_MEM, 16'h4501);
        wr(`MATS_A_CTRL, 16'h0003);
        wait_idle();
        chk_tx("ATE");
        chk_rd(`MATS_A_STAT, 16'h003c);
        rd(`MATS_A_FLAG);
        chk(rdv & 16'h1010, 16'h1000);
    endtask
    task automatic t_ans_rst;
        wr(`MATS_A_CTRL, 16'h0009);
        chk_rd(`MATS_A_STAT, 16'h001a);
        wait_idle();
        chk_tx("ATZ\x0d\x0a");
        rd(`MATS_A_FLAG);
        chk(rdv & 16'h4040, 16'h0040);
    endtask
    // slow modem; a general start lands while busy and must be dropped
    task automatic t_ans_full;
        slow <= 1'b1;
        wr(`MATS_A_CTRL, 16'h0005);
        wr(`MATS_A_CTRL, 16'h0003);
        chk_rd(`MATS_A_STAT, 16'h0019);
        wait_idle();
        chk_tx(string'({"ATE0Q0V1&D2&C1\\V0X4&K3\\A0\\N5S0=2&W\x0d\x0a",
                        "ATZ\x0d\x0a"}));
        chk_rd(`MATS_A_STAT, 16'h0032);
        rd(`MATS_A_FLAG);
        chk(rdv & 16'h6060, 16'h0060);
        slow <= 1'b0;
        wr(`MATS_A_CTRL, 16'h0000);
        chk_rd(`MATS_A_STAT, 16'h0000);
    endtask
    // originate with carrier present, a refused start online, then the hang-up
    task automatic t_dial;
        wr(`MATS_A_CTRL, 16'h0001);
        wr(`MATS_A_PROT, 16'h0001);
        wr(`MATS_A_MEM + 10'd160, 16'h3132);
        wr(`MATS_A_MEM + 10'd164, 16'h0d00);
        carrier <= 1'b1;
        wr(`MATS_A_CTRL, 16'h0011);
        wait_idle();
        chk_tx(string'({"ATE0Q0V1&D2&C1\\V0X4&K3\\A0\\N5S0=2&W\x0d\x0a",
                        "ATZ\x0d\x0aATD12\x0d\x0a"}));
        chk_rd(`MATS_A_STAT, 16'h0028);
        chk({13'h0000, dtr, lineConnected, userProtocol}, 16'h0007);
        wr(`MATS_A_CTRL, 16'h0003);
        chk_rd(`MATS_A_STAT, 16'h003e);
        wr(`MATS_A_CTRL, 16'h0021);
        wait_idle();
        carrier <= 1'b0;
        chk({13'h0000, dtr, lineConnected, userProtocol}, 16'h0004);
        chk_rd(`MATS_A_STAT, 16'h000a);
        rd(`MATS_A_FLAG);
        chk(rdv & 16'h0f0f, 16'h000f);
    endtask
    initial
    begin
        rst_n = 1'b0;
        regAddr = 10'h000;
        regWrData = 16'h0000;
        regWrite = 1'b0;
        regRead = 1'b0;
        replyOk = 1'b1;
        slow = 1'b0;
        carrier = 1'b0;
        mismatches = 0;
        totalChecks = 0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_enable();
        t_gen_fail();
        t_gen_ok();
        t_multi();
        t_prog();
        t_ans_rst();
        t_ans_full();
        t_dial();
        give_verdict();
    end
endmodule
`default_nettype wire
